// ---- dv/rtc_osc_control_capture_regs_bench.sv ----
// Purpose: self-checking bench for the oscillator register and snapshot block
// Assumes: the bench plays the timer core and the outer control register
// Notes: a short step interval keeps the capacitance stepping runs brief
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_control_capture_regs_bench;
  import rtcosc_pkg::*;
  localparam logic [3:0] CAP_R = 4'h5;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  rtcosc_req_t req = '0;
  logic [7:0] rdata;
  logic load_rq = 1'b0;
  logic snap_rq = 1'b0;
  logic load_strobe, snap_strobe, load_busy, snap_busy;
  logic [31:0] load_value;
  logic load_done = 1'b0;
  logic snap_done = 1'b0;
  logic [31:0] snap_value = 32'h0000_0000;
  logic [1:0] timer_step_lsb;
  logic amplitude_raw = 1'b0;
  rtcosc_osc_t osc;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] v;
  logic [7:0] w;

  rtcosc_regs #(.CAP_RESET(CAP_R), .STEP_CYCLES(2)) rtcosc_regs_i (
    .clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .timer_load_request(load_rq), .timer_snapshot_request(snap_rq),
    .load_strobe(load_strobe), .snap_strobe(snap_strobe), .load_value(load_value),
    .load_done(load_done), .snap_done(snap_done), .snap_value(snap_value),
    .timer_step_lsb(timer_step_lsb), .load_busy(load_busy), .snap_busy(snap_busy),
    .amplitude_raw(amplitude_raw), .osc(osc));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
  endtask

  // read results land one edge after the strobe; compare them mid-cycle
  always @(posedge clock) rd_d <= req.rd;
  always @(negedge clock) begin
    if (rd_d) check({24'h0, rdata}, {24'h0, exp_q.pop_front()});
  end

  // plays the timer core: one strobe, then a done pulse carrying the value
  task automatic xfer(input logic snap, input logic [31:0] val);
    int i;
    @(posedge clock);
    if (snap) snap_rq <= 1'b1;
    else load_rq <= 1'b1;
    for (i = 0; i < 10 && !(snap ? snap_strobe : load_strobe); i++) begin
      @(posedge clock);
      #1;
    end
    check(snap ? {snap_strobe, snap_busy} : {load_strobe, load_busy}, 2'b11);
    if (!snap) check(load_value, val);
    @(posedge clock);
    load_done <= !snap;
    snap_done <= snap;
    snap_value <= val;
    @(posedge clock);
    {load_done, snap_done} <= 2'b00;
    snap_value <= ~val;
    for (i = 0; i < 10 && (load_busy | snap_busy); i++) begin
      @(posedge clock);
      #1;
    end
    check({load_busy, snap_busy}, 2'b00);
    @(posedge clock);
    {load_rq, snap_rq} <= 2'b00;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hf547_e745));
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd(8'h05, 8'h00);
    rd(8'h06, {4'h4, CAP_R});
    for (int a = 0; a < 5; a++) rd(a[7:0], 8'h00);
    rd(8'h07, 8'h00);
    // control bits, amplitude low then high
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'hE8);
    check({osc.gain_ctrl_on, osc.osc_type_sel, osc.bias_double_on,
           osc.internal_slow_osc_sel, timer_step_lsb}, 6'h3E);
    amplitude_raw <= 1'b1;
    repeat (6) @(posedge clock);
    for (int k = 0; k < 6; k++) begin
      w = $urandom();
      wr(8'h05, w);
      rd(8'h05, (w & 8'hE8) | {3'b000, w[5], 4'h0});
      #1;
      check(timer_step_lsb, w[3] ? 2'b10 : 2'b01);
    end
    // stepping off: applied follows target; stepping on: applied restarts low and climbs to target; bits 5:4 ignore writes
    wr(8'h06, 8'h3F);
    rd(8'h06, 8'h4F);
    wr(8'h06, 8'h8A);
    rd(8'h06, 8'h8A);
    check(osc.applied_cap < 4'hA, 1'b1);
    repeat (40) @(posedge clock);
    rd(8'h06, 8'hCA);
    check(osc.applied_cap, 4'hA);
    // load: bytes written, then request, value handed over whole
    v = $urandom();
    for (int a = 0; a < 4; a++) wr(a[7:0], v[8*a +: 8]);
    for (int a = 0; a < 4; a++) rd(a[7:0], v[8*a +: 8]);
    xfer(1'b0, v);
    // snapshot: timer value lands in all four bytes at once, lowest byte at address 0
    v = $urandom();
    xfer(1'b1, v);
    for (int a = 0; a < 4; a++) rd(a[7:0], v[8*a +: 8]);
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- logic/rtcosc_pkg.sv ----
// Purpose: shared constants and carrier types for the clock oscillator register block
// Assumes: byte-wide indirect register port, addresses as given below
// Notes: the load capacitance reset value is a module parameter of the top
package rtcosc_pkg;

  localparam logic [7:0] RTCOSC_ADDR_SNAP0 = 8'h00;
  localparam logic [7:0] RTCOSC_ADDR_SNAP3 = 8'h03;
  localparam logic [7:0] RTCOSC_ADDR_CTRL = 8'h05;
  localparam logic [7:0] RTCOSC_ADDR_CFG = 8'h06;

  // oscillator control fields
  localparam int RTCOSC_CTRL_GAIN_BIT = 7;
  localparam int RTCOSC_CTRL_TYPE_BIT = 6;
  localparam int RTCOSC_CTRL_BIAS_BIT = 5;
  localparam int RTCOSC_CTRL_AMP_BIT = 4;
  localparam int RTCOSC_CTRL_SLOW_BIT = 3;
  localparam logic [7:0] RTCOSC_CTRL_RESET = 8'h00;

  // oscillator configuration fields
  localparam int RTCOSC_CFG_STEP_BIT = 7;
  localparam int RTCOSC_CFG_RDY_BIT = 6;
  localparam int RTCOSC_CFG_CAP_LSB = 0;
  localparam int RTCOSC_CFG_CAP_W = 4;
  localparam logic [3:0] RTCOSC_CAP_MIN = 4'h0;

  localparam logic [31:0] RTCOSC_SNAP_RESET = 32'h0000_0000;

  // cycles of the system clock between load capacitance steps
  localparam int RTCOSC_STEP_CYCLES = 16;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcosc_req_t;

  // oscillator steering outputs
  typedef struct packed {
    logic gain_ctrl_on;
    logic osc_type_sel;
    logic bias_double_on;
    logic internal_slow_osc_sel;
    logic [3:0] applied_cap;
  } rtcosc_osc_t;

  typedef enum logic [2:0] {
    RTCOSC_IDLE = 3'b001,
    RTCOSC_LOAD = 3'b010,
    RTCOSC_SNAP = 3'b100
  } rtcosc_xfer_t;

endpackage

// ---- logic/rtcosc_regs.sv ----
// Purpose: oscillator control/config registers and timer snapshot window
// Assumes: timer core answers load and snapshot handshakes on the system clock
// Notes: amplitude pin comes from the analog detector and is resynchronised
`timescale 1ns/1ps
`default_nettype none

module rtcosc_regs
  import rtcosc_pkg::*;
#(
  parameter logic [3:0] CAP_RESET = 4'h0,
  parameter int STEP_CYCLES = RTCOSC_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire rtcosc_req_t req,
  output logic [7:0] rdata,
  input wire logic timer_load_request,
  input wire logic timer_snapshot_request,
  output logic load_strobe,
  output logic snap_strobe,
  output logic [31:0] load_value,
  input wire logic load_done,
  input wire logic snap_done,
  input wire logic [31:0] snap_value,
  output logic [1:0] timer_step_lsb,
  output logic load_busy,
  output logic snap_busy,
  input wire logic amplitude_raw,
  output rtcosc_osc_t osc
);

  // ------------------------------------------------------------------
  // control and configuration registers
  // ------------------------------------------------------------------
  logic gain_q, type_q, bias_q, slow_q;
  logic step_q;
  logic [3:0] target_q;
  logic [3:0] applied_q;
  logic [31:0] snap_q;
  logic [2:0] amp_sync_q;
  logic amp_q;
  rtcosc_xfer_t xfer_q;
  logic [7:0] rd_d;
  logic ctrl_wr, cfg_wr;
  // a finished request stays blocked until the outer logic has dropped its bit
  logic load_hold_q, snap_hold_q;
  logic cap_ready;
  logic [$clog2(STEP_CYCLES+1)-1:0] step_cnt_q;

  assign ctrl_wr = req.wr && req.addr == RTCOSC_ADDR_CTRL;
  assign cfg_wr = req.wr && req.addr == RTCOSC_ADDR_CFG;
  assign cap_ready = applied_q == target_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gain_q <= 1'b0;
      type_q <= 1'b0;
      bias_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (ctrl_wr) begin
      gain_q <= req.wdata[RTCOSC_CTRL_GAIN_BIT];
      type_q <= req.wdata[RTCOSC_CTRL_TYPE_BIT];
      bias_q <= req.wdata[RTCOSC_CTRL_BIAS_BIT];
      slow_q <= req.wdata[RTCOSC_CTRL_SLOW_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      step_q <= 1'b0;
      target_q <= CAP_RESET;
    end else if (cfg_wr) begin
      step_q <= req.wdata[RTCOSC_CFG_STEP_BIT];
      target_q <= req.wdata[RTCOSC_CFG_CAP_LSB +: RTCOSC_CFG_CAP_W];
    end
  end

  // ------------------------------------------------------------------
  // amplitude detector: three-stage sync, change taken when 2nd and 3rd agree
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      amp_sync_q <= 3'b000;
      amp_q <= 1'b0;
    end else begin
      amp_sync_q <= {amp_sync_q[1:0], amplitude_raw};
      if (amp_sync_q[2] == amp_sync_q[1]) begin
        amp_q <= amp_sync_q[2];
      end
    end
  end

  // ------------------------------------------------------------------
  // load capacitance stepper
  // ------------------------------------------------------------------
  // slow climb gives the crystal a fast start at low load before settling
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      applied_q <= CAP_RESET;
      step_cnt_q <= '0;
    end else if (cfg_wr && req.wdata[RTCOSC_CFG_STEP_BIT] && !step_q) begin
      applied_q <= RTCOSC_CAP_MIN;
      step_cnt_q <= '0;
    end else if (!step_q) begin
      applied_q <= target_q;
      step_cnt_q <= '0;
    end else if (applied_q > target_q) begin
      applied_q <= target_q;
    end else if (!cap_ready) begin
      if (step_cnt_q == STEP_CYCLES[$bits(step_cnt_q)-1:0] - 1'b1) begin
        step_cnt_q <= '0;
        applied_q <= applied_q + 4'h1;
      end else begin
        step_cnt_q <= step_cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // timer transfer sequencer
  // ------------------------------------------------------------------
  // the request bits are cleared by outer logic only after busy falls, so
  // without this hold the same request would start a second transfer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      load_hold_q <= 1'b0;
      snap_hold_q <= 1'b0;
    end else begin
      if (xfer_q == RTCOSC_LOAD && load_done) begin
        load_hold_q <= 1'b1;
      end else if (!timer_load_request) begin
        load_hold_q <= 1'b0;
      end
      if (xfer_q == RTCOSC_SNAP && snap_done) begin
        snap_hold_q <= 1'b1;
      end else if (!timer_snapshot_request) begin
        snap_hold_q <= 1'b0;
      end
    end
  end

  // load wins when both requests arrive together; snapshot then follows
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      xfer_q <= RTCOSC_IDLE;
      load_strobe <= 1'b0;
      snap_strobe <= 1'b0;
      load_busy <= 1'b0;
      snap_busy <= 1'b0;
    end else begin
      load_strobe <= 1'b0;
      snap_strobe <= 1'b0;
      case (xfer_q)
        RTCOSC_IDLE: begin
          if (timer_load_request && !load_hold_q) begin
            xfer_q <= RTCOSC_LOAD;
            load_strobe <= 1'b1;
            load_busy <= 1'b1;
          end else if (timer_snapshot_request && !snap_hold_q) begin
            xfer_q <= RTCOSC_SNAP;
            snap_strobe <= 1'b1;
            snap_busy <= 1'b1;
          end
        end
        RTCOSC_LOAD: begin
          if (load_done) begin
            xfer_q <= RTCOSC_IDLE;
            load_busy <= 1'b0;
          end
        end
        RTCOSC_SNAP: begin
          if (snap_done) begin
            xfer_q <= RTCOSC_IDLE;
            snap_busy <= 1'b0;
          end
        end
        default: begin
          xfer_q <= RTCOSC_IDLE;
        end
      endcase
    end
  end

  // snapshot store; hardware capture wins over a software byte write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      snap_q <= RTCOSC_SNAP_RESET;
    end else if (xfer_q == RTCOSC_SNAP && snap_done) begin
      snap_q <= snap_value;
    end else if (req.wr && req.addr <= RTCOSC_ADDR_SNAP3) begin
      snap_q[req.addr[1:0]*8 +: 8] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      load_value <= RTCOSC_SNAP_RESET;
    end else if (timer_load_request && !load_hold_q && xfer_q == RTCOSC_IDLE) begin
      load_value <= snap_q;
    end
  end

  // ------------------------------------------------------------------
  // read path and oscillator steering
  // ------------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (req.addr >= RTCOSC_ADDR_SNAP0 && req.addr <= RTCOSC_ADDR_SNAP3) begin
      rd_d = snap_q[req.addr[1:0]*8 +: 8];
    end else if (req.addr == RTCOSC_ADDR_CTRL) begin
      rd_d[RTCOSC_CTRL_GAIN_BIT] = gain_q;
      rd_d[RTCOSC_CTRL_TYPE_BIT] = type_q;
      rd_d[RTCOSC_CTRL_BIAS_BIT] = bias_q;
      rd_d[RTCOSC_CTRL_AMP_BIT] = amp_q && bias_q;
      rd_d[RTCOSC_CTRL_SLOW_BIT] = slow_q;
    end else if (req.addr == RTCOSC_ADDR_CFG) begin
      rd_d[RTCOSC_CFG_STEP_BIT] = step_q;
      rd_d[RTCOSC_CFG_RDY_BIT] = cap_ready;
      rd_d[RTCOSC_CFG_CAP_LSB +: RTCOSC_CFG_CAP_W] = target_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      osc <= '0;
      timer_step_lsb <= 2'b01;
    end else begin
      if (req.rd) begin
        rdata <= rd_d;
      end
      osc.gain_ctrl_on <= gain_q;
      osc.osc_type_sel <= type_q;
      osc.bias_double_on <= bias_q;
      osc.internal_slow_osc_sel <= slow_q;
      osc.applied_cap <= applied_q;
      timer_step_lsb <= slow_q ? 2'b10 : 2'b01;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_amp_gated_bias: assert property (req.rd && req.addr == RTCOSC_ADDR_CTRL && !bias_q
    |=> !rdata[RTCOSC_CTRL_AMP_BIT]) else $error("amplitude bit set without bias");
  a_ctrl_low_zero: assert property (req.rd && req.addr == RTCOSC_ADDR_CTRL
    |=> rdata[2:0] == 3'b000) else $error("control low bits not zero");
  a_cfg_gap_zero: assert property (req.rd && req.addr == RTCOSC_ADDR_CFG
    |=> rdata[5:4] == 2'b00) else $error("config gap bits not zero");
  a_gain_write: assert property (ctrl_wr |=> gain_q == $past(req.wdata[7]))
    else $error("gain bit not stored");
  a_ready_match: assert property (req.rd && req.addr == RTCOSC_ADDR_CFG
    |=> rdata[RTCOSC_CFG_RDY_BIT] == ($past(applied_q) == $past(target_q)))
    else $error("ready flag wrong");
  a_step_rate: assert property (slow_q ##1 slow_q |-> timer_step_lsb == 2'b10)
    else $error("slow oscillator step wrong");
  a_load_clear: assert property (xfer_q == RTCOSC_LOAD && load_done
    |=> !load_busy) else $error("load request not cleared");
  a_snap_copy: assert property (xfer_q == RTCOSC_SNAP && snap_done
    |=> snap_q == $past(snap_value) && !snap_busy) else $error("snapshot not stored");
  a_cap_monotone: assert property (step_q && $past(step_q) && applied_q <= target_q
    && !cfg_wr |=> applied_q >= $past(applied_q)) else $error("capacitance fell");

  c_load_done: cover property (xfer_q == RTCOSC_LOAD ##[1:20] !load_busy);
  c_snap_done: cover property (xfer_q == RTCOSC_SNAP ##[1:20] !snap_busy);
  c_cap_reached: cover property (step_q && !cap_ready ##[1:400] cap_ready);

endmodule

`default_nettype wire
